// ==== hw/wdrp_pkg.sv ====
// Package: constants for the write data and write response port
package wdrp_pkg;
	// Register offsets (byte addresses)
	localparam logic [7:0] WDRP_OFF_CTRL   = 8'h00;
	localparam logic [7:0] WDRP_OFF_STATUS = 8'h04;
	localparam logic [7:0] WDRP_OFF_LASTID = 8'h08;
	localparam logic [7:0] WDRP_OFF_SEL    = 8'h0c;
	localparam logic [7:0] WDRP_OFF_DATA   = 8'h10;
	// Control field positions
	localparam int WDRP_CTRL_EN_BIT    = 0;
	localparam int WDRP_CTRL_RESP_LSB  = 1;
	localparam int WDRP_CTRL_USER_LSB  = 8;
	// Selection field positions
	localparam int WDRP_SEL_ENT_LSB    = 0;
	localparam int WDRP_SEL_SLICE_LSB  = 8;
	// Status field positions
	localparam int WDRP_STAT_BEAT_LSB  = 0;
	localparam int WDRP_STAT_BURST_LSB = 16;
	// Reset values
	localparam logic [31:0] WDRP_CTRL_RST = 32'h0000_0001;
	localparam logic [31:0] WDRP_SEL_RST  = 32'h0000_0000;
	// Response codes
	typedef enum logic [1:0] {
		WDRP_OKAY   = 2'b00,
		WDRP_EXOKAY = 2'b01,
		WDRP_SLVERR = 2'b10,
		WDRP_DECERR = 2'b11
	} wdrp_resp_t;
	// Width limits
	localparam int WDRP_SLV_ID_MAX  = 16;
	localparam int WDRP_MST_ID_MAX  = 24;
	localparam int WDRP_USER_MAX    = 256;
	localparam int WDRP_LANE_BITS   = 8;
	localparam int WDRP_REG_W       = 32;
endpackage

// ==== hw/wdrp_lane_merge.sv ====
// Byte-lane merge of a new data beat into a stored word
module wdrp_lane_merge #(
	parameter int DATA_W = 32
) (
	input  wire logic [DATA_W-1:0]   old_word,
	input  wire logic [DATA_W-1:0]   new_word,
	input  wire logic [DATA_W/8-1:0] strobe,
	output logic      [DATA_W-1:0]   merged
);
	// Each strobe bit picks one byte lane of the new beat
	for (genvar k = 0; k < DATA_W / 8; k++)
	begin : g_lane
		assign merged[8*k +: 8] = strobe[k] ? new_word[8*k +: 8]
			: old_word[8*k +: 8];
	end
endmodule

// ==== hw/wdrp_port.sv ====
// Write data and write response port, target end facing a bus master
//
// The placing of the registers and the plain strobed port are this design's own decisions.
module wdrp_port
	import wdrp_pkg::*;
#(
	parameter int DATA_W     = 32,
	parameter bit MST_SIDE   = 1'b0,
	parameter int SLV_ID_W   = 4,
	parameter int GLB_ID_W   = 8,
	parameter bit ID_REDUCE  = 1'b0,
	parameter int RED_ID_W   = 4,
	parameter int WUSER_W    = 0,
	parameter int BUSER_W    = 0,
	parameter int DEPTH      = 16
) (
	input  wire logic                    sys_clk,
	input  wire logic                    rst_b,
	input  wire logic [((MST_SIDE ? (ID_REDUCE ? RED_ID_W : GLB_ID_W)
		: SLV_ID_W) > 0 ? (MST_SIDE ? (ID_REDUCE ? RED_ID_W : GLB_ID_W)
		: SLV_ID_W) : 1)-1:0]            wid_s,
	input  wire logic [DATA_W-1:0]       wdata_s,
	input  wire logic [DATA_W/8-1:0]     wstrb_s,
	input  wire logic                    wlast_s,
	input  wire logic [(WUSER_W > 0 ? WUSER_W : 1)-1:0] wuser_s,
	input  wire logic                    wvalid_s,
	output logic                         wready_s,
	output logic [((MST_SIDE ? (ID_REDUCE ? RED_ID_W : GLB_ID_W)
		: SLV_ID_W) > 0 ? (MST_SIDE ? (ID_REDUCE ? RED_ID_W : GLB_ID_W)
		: SLV_ID_W) : 1)-1:0]                 bid_s,
	output wdrp_pkg::wdrp_resp_t         bresp_s,
	output logic [(BUSER_W > 0 ? BUSER_W : 1)-1:0] buser_s,
	output logic                         bvalid_s,
	input  wire logic                    bready_s,
	input  wire logic [7:0]              reg_addr,
	input  wire logic [31:0]             reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic [31:0]                  reg_rdata
);
	import wdrp_pkg::*;

	// Port width of the ID, never below one bit
	function automatic int wdrp_port_id_pw(bit ms, int sw, int gw, bit rd,
		int rw);
		int w;
		w = ms ? (rd ? rw : gw) : sw;
		return (w > 0) ? w : 1;
	endfunction

	localparam int ID_W  = MST_SIDE ? (ID_REDUCE ? RED_ID_W : GLB_ID_W)
		: SLV_ID_W;
	localparam int ID_PW = wdrp_port_id_pw(MST_SIDE, SLV_ID_W, GLB_ID_W,
		ID_REDUCE, RED_ID_W);
	localparam int WU_PW = (WUSER_W > 0) ? WUSER_W : 1;
	localparam int BU_PW = (BUSER_W > 0) ? BUSER_W : 1;
	localparam int LANES = DATA_W / WDRP_LANE_BITS;
	localparam int SLICES = DATA_W / WDRP_REG_W;
	localparam int ENT_AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int SL_AW  = (SLICES > 1) ? $clog2(SLICES) : 1;
	localparam bit WIDTH_OK = (DATA_W == 32) || (DATA_W == 64)
		|| (DATA_W == 128) || (DATA_W == 256);
	localparam bit ID_OK = MST_SIDE ? (ID_W >= 1 && ID_W <= WDRP_MST_ID_MAX)
		: (ID_W >= 0 && ID_W <= WDRP_SLV_ID_MAX);
	localparam bit USER_OK = (WUSER_W <= WDRP_USER_MAX)
		&& (BUSER_W <= WDRP_USER_MAX);

	// Registers
	logic [31:0]        ctrl_q;
	logic [31:0]        ctrl_d;
	logic [31:0]        sel_q;
	logic [31:0]        sel_d;
	logic [15:0]        beats_q;
	logic [15:0]        bursts_q;
	logic [ID_PW-1:0]   last_id_q;
	logic [ENT_AW-1:0]  beat_idx_q;
	logic               wready_q;
	logic               bvalid_q;
	logic               bvalid_d;
	logic [ID_PW-1:0]   bid_q;
	wdrp_resp_t         bresp_q;
	logic [BU_PW-1:0]   buser_q;
	logic [31:0]        rdata_q;
	logic [31:0]        rdata_d;
	logic [DATA_W-1:0]  store_q [DEPTH];
	logic [WU_PW-1:0]   wuser_last_q;

	// Decode and handshake terms
	wire               cfg_ok   = WIDTH_OK && ID_OK && USER_OK;
	wire               w_fire   = wvalid_s && wready_q;
	wire               b_fire   = bvalid_q && bready_s;
	wire               last_acc = w_fire && wlast_s;
	wire               accept_en = ctrl_q[WDRP_CTRL_EN_BIT] && cfg_ok;
	wire               hit_ctrl = reg_addr == WDRP_OFF_CTRL;
	wire               hit_sel  = reg_addr == WDRP_OFF_SEL;
	wire [ID_PW-1:0]   wid_use  = (ID_W > 0) ? wid_s : '0;
	wire [WU_PW-1:0]   wuser_use = (WUSER_W > 0) ? wuser_s : '0;
	wire [ENT_AW-1:0]  sel_ent  = sel_q[WDRP_SEL_ENT_LSB +: ENT_AW];
	wire [SL_AW-1:0]   sel_sl   = sel_q[WDRP_SEL_SLICE_LSB +: SL_AW];
	wire [DATA_W-1:0]  sel_word = store_q[sel_ent];
	wire [DATA_W-1:0]  sel_shft = sel_word >> {sel_sl, 5'h00};
	wire [1:0]         resp_cfg = ctrl_q[WDRP_CTRL_RESP_LSB +: 2];
	wire [7:0]         user_cfg = ctrl_q[WDRP_CTRL_USER_LSB +: 8];
	wire [DATA_W-1:0]  merged;
	wire wdrp_resp_t   resp_nx  = wdrp_resp_t'(resp_cfg);
	wire [BU_PW-1:0]   buser_nx = (BUSER_W > 0) ? BU_PW'(user_cfg) : '0;

	// Next slot, wrapping at DEPTH even when not a power of two
	wire               idx_wrap = beat_idx_q == ENT_AW'(DEPTH - 1);
	wire [ENT_AW-1:0]  idx_next = idx_wrap ? '0 : beat_idx_q + 1'b1;

	// Lane-wise merge of the current beat into its slot
	wdrp_lane_merge #(
		.DATA_W (DATA_W)
	) u_merge (
		.old_word (store_q[beat_idx_q]),
		.new_word (wdata_s),
		.strobe   (wstrb_s),
		.merged   (merged)
	);

	// Response stays pending until the master takes it
	assign bvalid_d = (bvalid_q && !bready_s) || last_acc;
	assign ctrl_d   = (reg_wr && hit_ctrl) ? reg_wdata : ctrl_q;
	assign sel_d    = (reg_wr && hit_sel) ? reg_wdata : sel_q;

	// Read data mux, zero outside the answer cycle
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (reg_rd)
		begin
			case (reg_addr)
				WDRP_OFF_CTRL:   rdata_d = ctrl_q;
				WDRP_OFF_STATUS: rdata_d = {bursts_q, beats_q};
				WDRP_OFF_LASTID: rdata_d = 32'(last_id_q);
				WDRP_OFF_SEL:    rdata_d = sel_q;
				WDRP_OFF_DATA:   rdata_d = sel_shft[31:0];
				default:         rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Register port state
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			ctrl_q  <= WDRP_CTRL_RST;
			sel_q   <= WDRP_SEL_RST;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			ctrl_q  <= ctrl_d;
			sel_q   <= sel_d;
			rdata_q <= rdata_d;
		end
	end

	// Write data channel: accept beats while no response waits
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			wready_q   <= 1'b0;
			beat_idx_q <= '0;
			beats_q    <= 16'h0000;
			bursts_q   <= 16'h0000;
			last_id_q  <= '0;
			wuser_last_q <= '0;
		end
		else
		begin
			wready_q <= accept_en && !bvalid_d;
			if (w_fire)
			begin
				beat_idx_q   <= last_acc ? '0 : idx_next;
				beats_q      <= beats_q + 16'h0001;
				wuser_last_q <= wuser_use;
			end
			if (last_acc)
			begin
				bursts_q  <= bursts_q + 16'h0001;
				last_id_q <= wid_use;
			end
		end
	end

	// Beat storage, only strobed lanes change
	always_ff @(posedge sys_clk)
	begin
		if (w_fire)
			store_q[beat_idx_q] <= merged;
	end

	// Write response channel
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			bvalid_q <= 1'b0;
			bid_q    <= '0;
			bresp_q  <= WDRP_OKAY;
			buser_q  <= '0;
		end
		else
		begin
			bvalid_q <= bvalid_d;
			if (last_acc)
			begin
				bid_q   <= wid_use;
				bresp_q <= resp_nx;
				buser_q <= buser_nx;
			end
		end
	end

	// Outputs, bridge slave naming with _s suffix
	assign wready_s  = wready_q;
	assign bvalid_s  = bvalid_q;
	assign bid_s     = bid_q;
	assign bresp_s   = bresp_q;
	assign buser_s   = buser_q;
	assign reg_rdata = rdata_q;
endmodule

// ==== verification/wdrp_checker.sv ====
// Assertion checker on the port pins of the write data and response port
module wdrp_checker
	import wdrp_pkg::*;
(
	input wire logic                 sys_clk,
	input wire logic                 rst_b,
	input wire logic [3:0]           wid_s,
	input wire logic                 wlast_s,
	input wire logic                 wvalid_s,
	input wire logic                 wready_s,
	input wire logic [3:0]           bid_s,
	input wire wdrp_pkg::wdrp_resp_t bresp_s,
	input wire logic                 bvalid_s,
	input wire logic                 bready_s,
	input wire logic                 reg_rd,
	input wire logic [31:0]          reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Response channel holds and answers
	property p_bv_hold;
		bvalid_s && !bready_s |=> bvalid_s;
	endproperty
	a_bv_hold: assert property (p_bv_hold)
		else $error("bvalid dropped");
	property p_bid_hold;
		bvalid_s && !bready_s |=> $stable(bid_s);
	endproperty
	a_bid_hold: assert property (p_bid_hold)
		else $error("bid moved");
	property p_resp_hold;
		bvalid_s && !bready_s |=> $stable(bresp_s);
	endproperty
	a_resp_hold: assert property (p_resp_hold)
		else $error("bresp moved");
	property p_last_id;
		wvalid_s && wready_s && wlast_s |=> bvalid_s && bid_s == $past(wid_s);
	endproperty
	a_last_id: assert property (p_last_id)
		else $error("bad response id");
	property p_pend;
		bvalid_s |-> !wready_s;
	endproperty
	a_pend: assert property (p_pend)
		else $error("ready while pending");
	property p_back;
		bvalid_s && bready_s |=> !bvalid_s && wready_s;
	endproperty
	a_back: assert property (p_back)
		else $error("no return to ready");
	property p_cause;
		$rose(bvalid_s) |-> $past(wvalid_s) && $past(wready_s)
			&& $past(wlast_s);
	endproperty
	a_cause: assert property (p_cause)
		else $error("response without last beat");
	property p_rd_idle;
		reg_rdata != 32'h0 |-> $past(reg_rd);
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("stray read data");
	// Main scenarios reached
	c_slow: cover property (bvalid_s && !bready_s);
	c_b2b: cover property (wvalid_s && wready_s ##1 wvalid_s && wready_s);
	c_rd: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule

// ==== verification/wdrp_mst_model.sv ====
// Bus master model: drives write beats and takes responses
module wdrp_mst_model
	import wdrp_pkg::*;
(
	input  wire logic                 sys_clk,
	input  wire logic                 wready_s,
	input  wire logic                 bvalid_s,
	input  wire logic [3:0]           bid_s,
	input  wire wdrp_pkg::wdrp_resp_t bresp_s,
	output logic      [3:0]           wid_s,
	output logic      [31:0]          wdata_s,
	output logic      [3:0]           wstrb_s,
	output logic                      wlast_s,
	output logic                      wvalid_s,
	output logic                      bready_s
);
	timeunit 1ns;
	timeprecision 1ns;
	int n;
	initial
	begin
		{wid_s, wdata_s, wstrb_s, wlast_s, wvalid_s, bready_s} = '0;
	end
	// Beat held until taken; entered just after an edge
	task automatic beat(input logic [3:0] id, input logic [31:0] d,
		input logic [3:0] s, input logic l);
		n = 0;
		wvalid_s <= 1'b1;
		wid_s <= id;
		wdata_s <= d;
		wstrb_s <= s;
		wlast_s <= l;
		do @(posedge sys_clk); while (!wready_s && ++n < 50);
		if (n == 50) wdrp_port_tb.tmo();
	endtask
	// Drop valid after a burst; data and strobe lines do not keep the value
	task automatic idle();
		wvalid_s <= 1'b0;
		wdata_s <= ~wdata_s;
		wstrb_s <= ~wstrb_s;
	endtask
	// Response taken after slow cycles of stall
	task automatic resp(input int slow, output logic [3:0] id,
		output logic [1:0] r);
		n = 0;
		repeat (slow) @(posedge sys_clk);
		bready_s <= 1'b1;
		do @(posedge sys_clk); while (!bvalid_s && ++n < 50);
		if (n == 50) wdrp_port_tb.tmo();
		id = bid_s;
		r = bresp_s;
		bready_s <= 1'b0;
	endtask
endmodule

// ==== verification/wdrp_port_tb.sv ====
// Testbench for the write data and write response port
module wdrp_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import wdrp_pkg::*;
	logic sys_clk = 0, rst_b = 0, wlast_s, wvalid_s, wready_s, bvalid_s;
	logic bready_s, reg_wr = 0, reg_rd = 0;
	logic [3:0] wid_s, wstrb_s, bid_s, id;
	logic [31:0] wdata_s, reg_wdata = 0, reg_rdata, v;
	logic [7:0] reg_addr = 0;
	logic [1:0] r;
	logic buser_s;
	wdrp_resp_t bresp_s;
	int error_cnt, cmp_count;
	wdrp_port dut (.sys_clk(sys_clk), .rst_b(rst_b), .wid_s(wid_s),
		.wdata_s(wdata_s), .wstrb_s(wstrb_s), .wlast_s(wlast_s),
		.wuser_s(1'b0), .wvalid_s(wvalid_s), .wready_s(wready_s),
		.bid_s(bid_s), .bresp_s(bresp_s), .buser_s(buser_s),
		.bvalid_s(bvalid_s), .bready_s(bready_s), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	wdrp_mst_model m (.sys_clk(sys_clk), .wready_s(wready_s),
		.bvalid_s(bvalid_s), .bid_s(bid_s), .bresp_s(bresp_s),
		.wid_s(wid_s), .wdata_s(wdata_s), .wstrb_s(wstrb_s),
		.wlast_s(wlast_s), .wvalid_s(wvalid_s), .bready_s(bready_s));
	always #10 sys_clk = ~sys_clk;
	// Compare one value
	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	// Register port write and read
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk) reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk) reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge sys_clk);
	endtask
	// Reset values, unmapped and read-only places
	task automatic t_regs();
		rd(WDRP_OFF_CTRL, v);
		chk("ctrl", WDRP_CTRL_RST, v);
		rd(WDRP_OFF_SEL, v);
		chk("sel", WDRP_SEL_RST, v);
		wr(WDRP_OFF_STATUS, 32'hffff_ffff);
		rd(WDRP_OFF_STATUS, v);
		chk("status ro", 32'h0, v);
		rd(8'h20, v);
		chk("unmapped", 32'h0, v);
		wr(WDRP_OFF_CTRL, 32'h0);
		@(posedge sys_clk);
		chk("wready off", 32'h0, 32'(wready_s));
		wr(WDRP_OFF_CTRL, 32'h1);
		@(posedge sys_clk);
		chk("wready on", 32'h1, 32'(wready_s));
		$display("t_regs done");
	endtask
	// Every response code, with stalls on the response side
	task automatic t_resp();
		for (int c = 0; c < 4; c++)
		begin
			wr(WDRP_OFF_CTRL, 32'h1 | (c << 1));
			m.beat(4'(c + 5), 32'h0, 4'h0, 1'b1);
			m.idle();
			m.resp(c, id, r);
			chk("bid", 32'(c + 5), 32'(id));
			chk("bresp", 32'(c), 32'(r));
			chk("buser", 32'h0, 32'(buser_s));
		end
		$display("t_resp done");
	endtask
	// Back-to-back beats, then a partial strobe over slot 0
	task automatic t_lanes();
		m.beat(4'ha, 32'h1122_3344, 4'hf, 1'b0);
		m.beat(4'ha, 32'h5566_7788, 4'hf, 1'b0);
		m.beat(4'ha, 32'h99aa_bbcc, 4'hf, 1'b1);
		m.idle();
		m.resp(0, id, r);
		chk("bid burst", 32'ha, 32'(id));
		m.beat(4'h3, 32'haabb_ccdd, 4'b0101, 1'b1);
		m.idle();
		m.resp(1, id, r);
		wr(WDRP_OFF_SEL, 32'h0);
		rd(WDRP_OFF_DATA, v);
		chk("slot0", 32'h11bb_33dd, v);
		wr(WDRP_OFF_SEL, 32'h2);
		rd(WDRP_OFF_DATA, v);
		chk("slot2", 32'h99aa_bbcc, v);
		rd(WDRP_OFF_STATUS, v);
		chk("status", {16'd6, 16'd8}, v);
		rd(WDRP_OFF_LASTID, v);
		chk("lastid", 32'h3, v);
		$display("t_lanes done");
	endtask
	// Closing report
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic tmo();
		error_cnt++;
		summarize();
	endtask
	initial
	begin
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		t_regs();
		t_resp();
		t_lanes();
		summarize();
	end
endmodule
bind wdrp_port wdrp_checker chk_i (.sys_clk(sys_clk), .rst_b(rst_b),
	.wid_s(wid_s), .wlast_s(wlast_s), .wvalid_s(wvalid_s),
	.wready_s(wready_s), .bid_s(bid_s), .bresp_s(bresp_s),
	.bvalid_s(bvalid_s), .bready_s(bready_s), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata));
